/* bef_map.svh */
`ifndef BEF_MAP_SVH
`define BEF_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB window
// ----------------------------------------------------------------
`define BEF_ADDR_W 12
`define BEF_CTRL_OFF 12'h000
`define BEF_COUNT_OFF 12'h004
`define BEF_STATUS_OFF 12'h008
`define BEF_INFO_OFF 12'h00C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define BEF_CTRL_CODE_LSB 0
`define BEF_CTRL_MASK_LSB 8
`define BEF_CTRL_EN_BIT 16
`define BEF_CODE_RESET 8'h00
`define BEF_MASK_RESET 8'h00
`define BEF_STAT_OVF_BIT 0
`define BEF_STAT_CFG_BIT 1
`define BEF_COUNT_RESET 32'h0000_0000

// ----------------------------------------------------------------
// Event codes and qualifier bits
// ----------------------------------------------------------------
`define BEF_CODE_EXEC 8'h88
`define BEF_CODE_MISP 8'h89
`define BEF_UM_CONDITIONAL_QUALIFIER 8'h01
`define BEF_UM_JMP 8'h02
`define BEF_UM_IND 8'h04
`define BEF_UM_RET 8'h08
`define BEF_UM_DCALL 8'h10
`define BEF_UM_ICALL 8'h20
`define BEF_UM_NTAKEN 8'h40
`define BEF_UM_TAKEN 8'h80
`define BEF_UM_ALL 8'hFF
`define BEF_UM_TYPES 8'h3F
`define BEF_UM_DIRS 8'hC0

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define BEF_LANES 4
`define BEF_SUM_W 3
`define BEF_CNT_W 32

`endif

/* bef_pkg.sv */
`include "bef_map.svh"

package bef_pkg;

  // ----------------------------------------------------------------
  // Branch report carried from the execution lanes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BEF_KIND_CONDITIONAL_QUALIFIER = 3'h0,
    BEF_KIND_JMP = 3'h1,
    BEF_KIND_IND = 3'h2,
    BEF_KIND_RET = 3'h3,
    BEF_KIND_DCALL = 3'h4,
    BEF_KIND_ICALL = 3'h5
  } bef_kind_t;

  typedef struct packed {
    logic valid;
    bef_kind_t kind;
    logic taken;
    logic mispred;
  } bef_report_t;

  typedef bef_report_t [`BEF_LANES-1:0] bef_report_vec_t;

  // Filter selection as software programs it
  typedef struct packed {
    logic en;
    logic [7:0] umask;
    logic [7:0] code;
  } bef_ctrl_t;

  // Type qualifier bit that a branch kind answers to
  function automatic logic [7:0] bef_kind_bit(input bef_kind_t kind);
    logic [7:0] bit_sel;
    bit_sel = 8'h00;
    unique case (kind)
      BEF_KIND_CONDITIONAL_QUALIFIER: bit_sel = `BEF_UM_CONDITIONAL_QUALIFIER;
      BEF_KIND_JMP: bit_sel = `BEF_UM_JMP;
      BEF_KIND_IND: bit_sel = `BEF_UM_IND;
      BEF_KIND_RET: bit_sel = `BEF_UM_RET;
      BEF_KIND_DCALL: bit_sel = `BEF_UM_DCALL;
      BEF_KIND_ICALL: bit_sel = `BEF_UM_ICALL;
      default: bit_sel = 8'h00;
    endcase
    return bit_sel;
  endfunction : bef_kind_bit

  // Byte-lane merge of an APB write into a 32-bit word
  function automatic logic [31:0] bef_merge(input logic [31:0] old_word,
                                            input logic [31:0] new_word,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return res;
  endfunction : bef_merge

endpackage : bef_pkg

/* bef_lane_match.sv */
`timescale 1ns/1ns
`include "bef_map.svh"

module bef_lane_match (
  input bef_pkg::bef_report_t rpt,
  input bef_pkg::bef_ctrl_t ctrl,
  output logic hit
);
  import bef_pkg::*;

  logic [7:0] type_bit;
  logic code_ok;
  logic type_hit;
  logic dir_hit;
  logic all_sel;

  // Qualifier decode for one executed branch
  always_comb
  begin
    type_bit = bef_kind_bit(rpt.kind);
    code_ok = (ctrl.code == `BEF_CODE_EXEC) ||
              ((ctrl.code == `BEF_CODE_MISP) && rpt.mispred);
    type_hit = |(ctrl.umask & `BEF_UM_TYPES & type_bit);
    dir_hit = (rpt.taken && ctrl.umask[7]) ||
              (!rpt.taken && ctrl.umask[6] && (rpt.kind == BEF_KIND_CONDITIONAL_QUALIFIER));
    all_sel = (ctrl.umask == `BEF_UM_ALL);
    hit = ctrl.en && rpt.valid && code_ok && (all_sel || (type_hit && dir_hit));
  end

endmodule : bef_lane_match

/* bef_filter.sv */
// Contract
// - Code 88H bit 01H picks executed conditional branches; needs 40H or 80H.
// - Code 88H bit 02H picks direct unconditional jumps; counts only with 80H.
// - Code 88H bit 04H picks indirect non-call non-return jumps; needs 80H.
// - Code 88H bit 08H picks near returns; counts only with 80H.
// - Code 88H bit 10H picks direct near calls; counts only with 80H.
// - Code 88H bit 20H picks indirect near calls; counts only with 80H.
// - Code 88H bit 40H qualifies not-taken branches, meaningful for conditionals only.
// - Code 88H bit 80H qualifies taken branches, combined with type bits.
// - Umask FFH counts every executed branch of the selected class.
// - Code 89H applies the same qualifiers to mispredicted branches only.
// - Code 89H type bits 04H..20H pick mispredicted kinds, needing 80H.
// - Code 89H bit 40H qualifies mispredicted not-taken conditionals.
// - Code 89H bit 80H qualifies mispredicted taken branches with type bits.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "bef_map.svh"

module bef_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`BEF_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire bef_pkg::bef_report_vec_t branch_rpt,
  output logic [`BEF_CNT_W-1:0] event_count,
  output logic count_overflow
);
  import bef_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bef_ctrl_t ctrl_reg;
  bef_ctrl_t ctrl_next;
  logic [`BEF_CNT_W-1:0] count_reg;
  logic [`BEF_CNT_W:0] count_sum;
  logic ovf_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [`BEF_SUM_W-1:0] hit_sum_reg;
  logic [`BEF_SUM_W-1:0] hit_sum_next;
  logic [`BEF_LANES-1:0] lane_hit;
  logic setup_phase;
  logic access_done;
  logic addr_mapped;
  logic wr_ctrl;
  logic wr_count;
  logic wr_status;
  logic cfg_valid;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] read_word;
  logic [31:0] ctrl_merged;

  // ----------------------------------------------------------------
  // Per-lane qualifier match
  // ----------------------------------------------------------------

  // One matcher per reporting lane
  // same matcher for both codes
  for (genvar g = 0; g < `BEF_LANES; g++)
  begin : g_lane
    bef_lane_match u_match (
      .rpt(branch_rpt[g]),
      .ctrl(ctrl_reg),
      .hit(lane_hit[g])
    );
  end

  always_comb
  begin
    hit_sum_next = '0;
    for (int i = 0; i < `BEF_LANES; i++)
    begin
      hit_sum_next = hit_sum_next + {{(`BEF_SUM_W-1){1'b0}}, lane_hit[i]};
    end
  end

  // Hits staged one cycle to keep the adder off the lane decode path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hit_sum_reg <= '0;
    end
    else
    begin
      hit_sum_reg <= hit_sum_next;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  // Phase and address decode
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_reg;
  assign addr_mapped = (paddr == `BEF_CTRL_OFF) || (paddr == `BEF_COUNT_OFF) ||
                       (paddr == `BEF_STATUS_OFF) || (paddr == `BEF_INFO_OFF);
  assign wr_ctrl = access_done && pwrite && (paddr == `BEF_CTRL_OFF);
  assign wr_count = access_done && pwrite && (paddr == `BEF_COUNT_OFF);
  assign wr_status = access_done && pwrite && (paddr == `BEF_STATUS_OFF);

  // selection must hold a type and a direction, or be all-ones
  assign cfg_valid = ((ctrl_reg.code == `BEF_CODE_EXEC) ||
                      (ctrl_reg.code == `BEF_CODE_MISP)) &&
                     ((ctrl_reg.umask == `BEF_UM_ALL) ||
                      ((|(ctrl_reg.umask & `BEF_UM_TYPES)) &&
                       (|(ctrl_reg.umask & `BEF_UM_DIRS))));

  // Register images for readback
  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`BEF_CTRL_CODE_LSB +: 8] = ctrl_reg.code;
    ctrl_word[`BEF_CTRL_MASK_LSB +: 8] = ctrl_reg.umask;
    ctrl_word[`BEF_CTRL_EN_BIT] = ctrl_reg.en;
    status_word = 32'h0000_0000;
    status_word[`BEF_STAT_OVF_BIT] = ovf_reg;
    status_word[`BEF_STAT_CFG_BIT] = cfg_valid;
    unique case (paddr)
      `BEF_CTRL_OFF: read_word = ctrl_word;
      `BEF_COUNT_OFF: read_word = count_reg;
      `BEF_STATUS_OFF: read_word = status_word;
      `BEF_INFO_OFF: read_word = 32'(`BEF_LANES);
      default: read_word = 32'h0000_0000;
    endcase
  end

  // Answer in the access phase straight after setup, no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (setup_phase)
    begin
      pready_reg <= 1'b1;
      prdata_reg <= pwrite ? 32'h0000_0000 : read_word;
      pslverr_reg <= !addr_mapped;
    end
    else if (access_done)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------

  // Byte-lane write of code, umask and enable
  always_comb
  begin
    ctrl_next = ctrl_reg;
    ctrl_merged = bef_merge(ctrl_word, pwdata, pstrb);
    if (wr_ctrl)
    begin
      ctrl_next.code = ctrl_merged[`BEF_CTRL_CODE_LSB +: 8];
      ctrl_next.umask = ctrl_merged[`BEF_CTRL_MASK_LSB +: 8];
      ctrl_next.en = ctrl_merged[`BEF_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= '{en: 1'b0, umask: `BEF_MASK_RESET, code: `BEF_CODE_RESET};
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ----------------------------------------------------------------
  // Event counter and overflow flag
  // ----------------------------------------------------------------

  // add the whole cycle's hit count
  assign count_sum = {1'b0, count_reg} + {{(`BEF_CNT_W+1-`BEF_SUM_W){1'b0}}, hit_sum_reg};

  // Software write wins; the staged hits of that cycle are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= `BEF_COUNT_RESET;
    end
    else if (wr_count)
    begin
      count_reg <= bef_merge(count_reg, pwdata, pstrb);
    end
    else
    begin
      count_reg <= count_sum[`BEF_CNT_W-1:0];
    end
  end

  // Sticky wrap flag, write one to clear; a wrap in the same cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_reg <= 1'b0;
    end
    else if (!wr_count && count_sum[`BEF_CNT_W])
    begin
      ovf_reg <= 1'b1;
    end
    else if (wr_status && pstrb[0] && pwdata[`BEF_STAT_OVF_BIT])
    begin
      ovf_reg <= 1'b0;
    end
  end

  // Outputs straight from flops
  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign event_count = count_reg;
  assign count_overflow = ovf_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Lane 0 shorthand for the checks below
  bef_report_t r0;
  assign r0 = branch_rpt[0];

  sequence s_exec_on;
    ctrl_reg.en && (ctrl_reg.code == `BEF_CODE_EXEC) && r0.valid;
  endsequence

  sequence s_misp_on;
    ctrl_reg.en && (ctrl_reg.code == `BEF_CODE_MISP) && r0.valid;
  endsequence

  sequence s_no_write;
    !wr_count;
  endsequence

  a_conditional_qualifier_needs_dir: assert property (
    s_exec_on and (ctrl_reg.umask == `BEF_UM_CONDITIONAL_QUALIFIER) |-> !lane_hit[0])
    else $error("conditional counted without direction bit");

  // direct jump only when taken selected
  a_jump_needs_taken: assert property (
    s_exec_on and (r0.kind == BEF_KIND_JMP) |-> lane_hit[0] ==
    ((ctrl_reg.umask == `BEF_UM_ALL) || (r0.taken && ctrl_reg.umask[7] && ctrl_reg.umask[1])))
    else $error("direct jump count mismatch");

  a_indirect_taken: assert property (
    s_exec_on and (r0.kind == BEF_KIND_IND) and
    (ctrl_reg.umask == (`BEF_UM_IND | `BEF_UM_TAKEN)) |-> lane_hit[0] == r0.taken)
    else $error("indirect jump count mismatch");

  a_return_taken: assert property (
    s_exec_on and (r0.kind == BEF_KIND_RET) and
    (ctrl_reg.umask == (`BEF_UM_RET | `BEF_UM_TAKEN)) |-> lane_hit[0] == r0.taken)
    else $error("return count mismatch");

  // direct call needs its own type bit
  a_dcall_select: assert property (
    s_exec_on and (r0.kind == BEF_KIND_DCALL) and r0.taken and ctrl_reg.umask[7] |->
    lane_hit[0] == ctrl_reg.umask[4])
    else $error("direct call count mismatch");

  // indirect call needs its own type bit
  a_icall_select: assert property (
    s_exec_on and (r0.kind == BEF_KIND_ICALL) and r0.taken and ctrl_reg.umask[7] |->
    lane_hit[0] == ctrl_reg.umask[5])
    else $error("indirect call count mismatch");

  a_not_taken_qualifier_conditional_qualifier: assert property (
    s_exec_on and !r0.taken and (ctrl_reg.umask == (`BEF_UM_CONDITIONAL_QUALIFIER | `BEF_UM_NTAKEN)) |->
    lane_hit[0] == (r0.kind == BEF_KIND_CONDITIONAL_QUALIFIER))
    else $error("not-taken conditional mismatch");

  // not-taken qualifier never picks a jump
  a_not_taken_qualifier_jump: assert property (
    s_exec_on and !r0.taken and (r0.kind == BEF_KIND_JMP) and
    (ctrl_reg.umask == (`BEF_UM_JMP | `BEF_UM_NTAKEN)) |-> !lane_hit[0])
    else $error("not-taken jump counted");

  // taken qualifier without a type never counts
  a_taken_needs_type: assert property (
    s_exec_on and (ctrl_reg.umask == `BEF_UM_TAKEN) |-> !lane_hit[0])
    else $error("taken qualifier counted without type bit");

  a_all_branches: assert property (
    s_exec_on and (ctrl_reg.umask == `BEF_UM_ALL) |-> lane_hit[0])
    else $error("all-branches missed a report");

  a_misp_only: assert property (
    s_misp_on |-> lane_hit[0] == 1'b0 || r0.mispred)
    else $error("well-predicted branch counted under mispredict code");

  // mispredicted return picked by its own bit
  a_misp_return: assert property (
    s_misp_on and r0.mispred and r0.taken and
    (ctrl_reg.umask == (`BEF_UM_RET | `BEF_UM_TAKEN)) |->
    lane_hit[0] == (r0.kind == BEF_KIND_RET))
    else $error("mispredicted return count mismatch");

  a_misp_not_taken_qualifier: assert property (
    s_misp_on and r0.mispred and !r0.taken and
    (r0.kind == BEF_KIND_CONDITIONAL_QUALIFIER) and (ctrl_reg.umask == 8'h41) |-> lane_hit[0])
    else $error("mispredicted not-taken conditional missed");

  // mispredicted conditional follows the taken bit
  a_misp_taken: assert property (
    s_misp_on and r0.mispred and (r0.kind == BEF_KIND_CONDITIONAL_QUALIFIER) and
    (ctrl_reg.umask == (`BEF_UM_CONDITIONAL_QUALIFIER | `BEF_UM_TAKEN)) |-> lane_hit[0] == r0.taken)
    else $error("mispredicted taken conditional mismatch");

  a_type_and_dir: assert property (
    s_exec_on and !r0.taken and
    (ctrl_reg.umask == (`BEF_UM_CONDITIONAL_QUALIFIER | `BEF_UM_TAKEN)) |-> !lane_hit[0])
    else $error("direction qualifier ignored");

  // counter advances by the hits staged two cycles back
  a_count_step: assert property (
    s_no_write ##1 s_no_write |->
    count_reg == $past(count_reg) + `BEF_CNT_W'($past(hit_sum_next, 2)))
    else $error("counter step does not match hit count");

endmodule : bef_filter

/* bef_core_model.sv */
`timescale 1ns/1ns
`include "bef_map.svh"

module bef_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire bef_pkg::bef_report_vec_t rpt_req,
  input wire logic [3:0] burst,
  input wire logic go,
  output bef_pkg::bef_report_vec_t branch_rpt
);
  import bef_pkg::*;

  logic [3:0] left_reg;

  // ----------------------------------------------------------------
  // Burst of reports
  // ----------------------------------------------------------------
  // Cycles still to present the requested lanes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      left_reg <= 4'h0;
    else if (go)
      left_reg <= burst;
    else if (left_reg != 4'h0)
      left_reg <= left_reg - 4'h1;
  end

  // Idle lanes show inverted fields so stale data never looks valid
  always_comb
  begin
    for (int l = 0; l < `BEF_LANES; l++)
    begin
      if (left_reg != 4'h0)
        branch_rpt[l] = rpt_req[l];
      else
      begin
        branch_rpt[l] = ~rpt_req[l];
        branch_rpt[l].valid = 1'h0;
      end
    end
  end
endmodule : bef_core_model

/* bef_filter_tb.sv */
`timescale 1ns/1ns
`include "bef_map.svh"

module bef_filter_tb;
  import bef_pkg::*;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] um;
    logic en;
    logic [2:0] kind;
    logic t;
    logic m;
    logic e;
  } bef_case_t;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, count_overflow, err;
  logic [`BEF_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, burst;
  logic [`BEF_CNT_W-1:0] event_count;
  bef_report_vec_t branch_rpt, rpt_req, mix;
  bef_report_t one;
  bef_case_t cases[$];
  int miscompares, checks_done;

  bef_filter i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .branch_rpt(branch_rpt),
    .event_count(event_count), .count_overflow(count_overflow));

  bef_core_model i_core (.pclk(pclk), .presetn(presetn), .rpt_req(rpt_req),
    .burst(burst), .go(go), .branch_rpt(branch_rpt));

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task tally_and_finish;
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; answer taken at the edge that samples pready high
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // Only the watchdog ends a wait that never sees pready
    while (pready !== 1'h1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Present lanes for b cycles, then let the staged sum land
  task send(input bef_report_vec_t v, input logic [3:0] b);
    @(posedge pclk);
    rpt_req <= v;
    burst <= b;
    go <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
    repeat (b + 6) @(posedge pclk);
    @(negedge pclk);
  endtask : send

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, go} = 5'h0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    burst = 4'h0;
    rpt_req = '0;
    miscompares = 0;
    checks_done = 0;
    cases.push_back('{8'h88, 8'h81, 1'h1, 3'h0, 1'h1, 1'h0, 1'h1});
    cases.push_back('{8'h88, 8'h41, 1'h1, 3'h0, 1'h0, 1'h0, 1'h1});
    cases.push_back('{8'h88, 8'h01, 1'h1, 3'h0, 1'h1, 1'h0, 1'h0});
    cases.push_back('{8'h88, 8'h82, 1'h1, 3'h1, 1'h1, 1'h0, 1'h1});
    cases.push_back('{8'h88, 8'h42, 1'h1, 3'h1, 1'h0, 1'h0, 1'h0});
    cases.push_back('{8'h88, 8'h84, 1'h1, 3'h2, 1'h1, 1'h0, 1'h1});
    cases.push_back('{8'h88, 8'h88, 1'h1, 3'h3, 1'h1, 1'h0, 1'h1});
    cases.push_back('{8'h88, 8'h90, 1'h1, 3'h4, 1'h1, 1'h0, 1'h1});
    cases.push_back('{8'h88, 8'hA0, 1'h1, 3'h5, 1'h1, 1'h0, 1'h1});
    cases.push_back('{8'h88, 8'h80, 1'h1, 3'h0, 1'h1, 1'h0, 1'h0});
    cases.push_back('{8'h88, 8'h82, 1'h1, 3'h0, 1'h1, 1'h0, 1'h0});
    cases.push_back('{8'h88, 8'hFF, 1'h1, 3'h3, 1'h0, 1'h0, 1'h1});
    cases.push_back('{8'h88, 8'hFF, 1'h0, 3'h0, 1'h1, 1'h0, 1'h0});
    cases.push_back('{8'h89, 8'h81, 1'h1, 3'h0, 1'h1, 1'h0, 1'h0});
    cases.push_back('{8'h89, 8'h81, 1'h1, 3'h0, 1'h1, 1'h1, 1'h1});
    cases.push_back('{8'h89, 8'h84, 1'h1, 3'h2, 1'h1, 1'h1, 1'h1});
    cases.push_back('{8'h89, 8'h88, 1'h1, 3'h3, 1'h1, 1'h1, 1'h1});
    cases.push_back('{8'h89, 8'h90, 1'h1, 3'h4, 1'h1, 1'h1, 1'h1});
    cases.push_back('{8'h89, 8'hA0, 1'h1, 3'h5, 1'h1, 1'h1, 1'h1});
    cases.push_back('{8'h89, 8'h41, 1'h1, 3'h0, 1'h0, 1'h1, 1'h1});
    cases.push_back('{8'h89, 8'hFF, 1'h1, 3'h1, 1'h0, 1'h1, 1'h1});
    cases.push_back('{8'h80, 8'hFF, 1'h1, 3'h0, 1'h1, 1'h1, 1'h0});
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    // Reset values, read-only place and unmapped address
    apb(`BEF_CTRL_OFF, 1'h0, 32'h0);
    check(rd, 32'h0);
    apb(`BEF_INFO_OFF, 1'h1, 32'h0);
    apb(`BEF_INFO_OFF, 1'h0, 32'h0);
    check(rd, `BEF_LANES);
    apb(12'h010, 1'h0, 32'h0);
    check(err, 1'h1);
    check(rd, 32'h0);
    // Four lanes for two cycles, per qualifier combination
    foreach (cases[i])
    begin
      apb(`BEF_CTRL_OFF, 1'h1, {15'h0, cases[i].en, cases[i].um, cases[i].code});
      apb(`BEF_COUNT_OFF, 1'h1, 32'h0);
      one = '{1'h1, bef_kind_t'(cases[i].kind), cases[i].t, cases[i].m};
      send({4{one}}, 4'h2);
      check(event_count, {28'h0, cases[i].e, 3'h0}); // Lane total
      apb(`BEF_COUNT_OFF, 1'h0, 32'h0);
      check(rd, {28'h0, cases[i].e, 3'h0}); // Per case
    end
    // Mixed lanes over three cycles: two hits each cycle
    mix[0] = '{1'h1, BEF_KIND_CONDITIONAL_QUALIFIER, 1'h1, 1'h0};
    mix[1] = '{1'h0, BEF_KIND_CONDITIONAL_QUALIFIER, 1'h1, 1'h0};
    mix[2] = '{1'h1, BEF_KIND_CONDITIONAL_QUALIFIER, 1'h1, 1'h1};
    mix[3] = '{1'h1, BEF_KIND_JMP, 1'h1, 1'h0};
    apb(`BEF_CTRL_OFF, 1'h1, 32'h0001_8188);
    apb(`BEF_COUNT_OFF, 1'h1, 32'h0);
    send(mix, 4'h3);
    check(event_count, 32'h6);
    // Wrap sets the sticky flag, one write clears it
    apb(`BEF_COUNT_OFF, 1'h1, 32'hFFFF_FFFE);
    one = '{1'h1, BEF_KIND_CONDITIONAL_QUALIFIER, 1'h1, 1'h0};
    send({4{one}}, 4'h1);
    check(count_overflow, 1'h1);
    check(event_count, 32'h2);
    apb(`BEF_STATUS_OFF, 1'h0, 32'h0);
    check(rd, 32'h3);
    apb(`BEF_STATUS_OFF, 1'h1, 32'h1);
    apb(`BEF_STATUS_OFF, 1'h0, 32'h0);
    check(rd, 32'h2);
    tally_and_finish();
  end
endmodule : bef_filter_tb
